// ===== rtl/ind_status_monitor.sv
// indicator status monitor: ten instances, event capture with ms stamps,
// apb register file and a level interrupt.
// assumes raw status pins from outside pclk; an apb master on pclk.
// Behaviour
// [RULE1] neither input active reports intermediate
// [RULE2] both inputs active reports bad
// [RULE3] open input at one means indicator open
// [RULE4] close input at one means indicator closed
// [RULE5] only open gives open, only close gives closed
// [RULE6] each of four state signals emits ON on rise, OFF on fall
// [RULE7] every event carries a one millisecond time stamp
// [RULE8] per instance selection keeps ON, OFF or both events
// [RULE9] single input use: outside feeds its inverse as second input
// [RULE10] block only indicates, drives no open or close controls
// [RULE11] settings change only in setup phase, not while running
// [RULE12] ten independent instances each with four state events
// [RULE13] each instance keeps a 32 character label, default indexed
`timescale 1ns/10ps
module ind_status_monitor (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	// status pins, one pair per instance
	input  wire ind_mon_pkg::status_in_t status_pins [ind_mon_pkg::N_INST],
	// interrupt, the only output besides the bus
	output logic                         irq  // RULE10
);

	localparam int N = ind_mon_pkg::N_INST;

	// ****************************************
	// input synchronisers and instances
	// ****************************************
	ind_mon_pkg::status_in_t sync1 [N];
	ind_mon_pkg::status_in_t sync2 [N];
	ind_mon_pkg::ind_state_t st    [N];
	logic [3:0]              rise  [N];
	logic [3:0]              fall  [N];
	logic [1:0]              sel   [N];
	logic [N*8-1:0]          pend;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_inst
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1[g] <= '0;
					sync2[g] <= '0;
				end else begin
					sync1[g] <= status_pins[g];
					sync2[g] <= sync1[g];
				end
			end

			ind_decode u_dec ( // RULE12
				.pclk     (pclk),
				.presetn  (presetn),
				.open_in  (sync2[g].open_in),
				.close_in (sync2[g].close_in),
				.state    (st[g]),
				.rise     (rise[g]),
				.fall     (fall[g])
			);
		end
	endgenerate

	// ****************************************
	// ms time base
	// ****************************************
	logic [16:0]                     ms_div;
	logic [ind_mon_pkg::TS_W-1:0]    ms_time;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_div  <= '0;
			ms_time <= '0;
		end else if (ms_div == 17'(ind_mon_pkg::MS_CYCLES - 1)) begin
			ms_div  <= '0;
			ms_time <= ms_time + 32'h1; // RULE7
		end else begin
			ms_div  <= ms_div + 17'h1;
		end
	end

	// ****************************************
	// pending events and arbiter
	// ****************************************
	// pend bit i*8+s: s<4 ON of signal s, s>=4 OFF of signal s-4
	logic        take;
	logic [6:0]  pick;
	logic        pick_ok;
	logic        evt_full;
	logic        ovf_evt;

	always_comb begin
		pick    = '0;
		pick_ok = 1'b0;
		for (int i = N*8-1; i >= 0; i--) begin
			if (pend[i]) begin
				pick    = 7'(i);
				pick_ok = 1'b1;
			end
		end
	end

	assign take = pick_ok && !evt_full;

	generate
		for (g = 0; g < N; g++) begin : g_pend
			logic [7:0] arrive;
			logic [7:0] clr;
			always_comb begin
				arrive = {fall[g] & {4{sel[g][ind_mon_pkg::CFG_OFF_BIT]}},
				          rise[g] & {4{sel[g][ind_mon_pkg::CFG_ON_BIT]}}};
				clr = '0;
				if (take && pick[6:3] == 4'(g))
					clr[pick[2:0]] = 1'b1;
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					pend[g*8 +: 8] <= '0;
				else // RULE6 RULE8
					pend[g*8 +: 8] <= (pend[g*8 +: 8] & ~clr) | arrive;
			end
		end
	endgenerate

	// a new edge on a still pending bit is merged: flagged as overflow
	always_comb begin
		ovf_evt = 1'b0;
		for (int i = 0; i < N; i++)
			if (|(pend[i*8 +: 8] & {fall[i], rise[i]}))
				ovf_evt = 1'b1;
	end

	// ****************************************
	// event slot (read side of common buffer)
	// ****************************************
	ind_mon_pkg::event_rec_t evt;
	logic                    evt_pop;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_full <= 1'b0;
			evt      <= '0;
		end else if (take) begin
			evt_full  <= 1'b1;
			evt.inst  <= pick[6:3];
			evt.sig   <= pick[1:0];
			evt.on    <= ~pick[2];
			evt.stamp <= ms_time; // RULE7
		end else if (evt_pop) begin
			evt_full <= 1'b0;
		end
	end

	// ****************************************
	// apb registers
	// ****************************************
	logic        run;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic [31:0] label [N][ind_mon_pkg::LABEL_WORDS];
	logic        acc;
	logic        wr;
	logic        in_inst;
	logic        in_label;
	logic [3:0]  idx;
	logic [2:0]  lword;
	logic        bad_addr;
	logic [31:0] rd;

	assign acc      = psel && penable;
	assign wr       = acc && pwrite && pready;
	assign in_inst  = paddr >= ind_mon_pkg::INST_BASE_OFF &&
	                  paddr < ind_mon_pkg::INST_BASE_OFF + 12'(N*4);
	assign in_label = paddr >= ind_mon_pkg::LABEL_BASE_OFF &&
	                  paddr < ind_mon_pkg::LABEL_BASE_OFF + 12'(N*32);
	assign idx      = in_label ? 4'(paddr[11:5] - 7'h10)
	                           : 4'(paddr[5:2]);
	assign lword    = paddr[4:2];
	assign evt_pop  = acc && !pwrite && pready &&
	                  paddr == ind_mon_pkg::EVT_TIME_OFF;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run <= 1'b0;
		else if (wr && paddr == ind_mon_pkg::CTRL_OFF)
			run <= pwdata[ind_mon_pkg::CTRL_RUN_BIT];
	end

	generate
		for (g = 0; g < N; g++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					sel[g] <= ind_mon_pkg::CFG_SEL_RST;
				else if (wr && !run && in_inst && idx == 4'(g)) // RULE11
					sel[g] <= pwdata[1:0];
			end
			for (genvar w = 0; w < ind_mon_pkg::LABEL_WORDS; w++) begin : g_l
				// default label: three letters plus index digit
				localparam logic [31:0] LBL_RST = (w == 0) ?
					{8'h30 + 8'(g), 8'h44, 8'h4E, 8'h49} : 32'h0;
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn)
						label[g][w] <= LBL_RST; // RULE13
					else if (wr && !run && in_label && idx == 4'(g) &&
					         lword == 3'(w))
						for (int b = 0; b < 4; b++)
							if (pstrb[b])
								label[g][w][b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
		end
	endgenerate

	// w1c, a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else begin
			irq_stat <= (irq_stat & ~((wr && paddr ==
			             ind_mon_pkg::IRQ_STAT_OFF) ? pwdata[1:0] : 2'h0))
			            | {ovf_evt, take};
			if (wr && paddr == ind_mon_pkg::IRQ_MASK_OFF)
				irq_mask <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	// read mux
	always_comb begin
		rd       = '0;
		bad_addr = 1'b0;
		if (in_inst && idx < 4'(N))
			rd = {20'h0, st[idx], 6'h0, sel[idx]};
		else if (in_label && idx < 4'(N))
			rd = label[idx][lword];
		else
			case (paddr)
				ind_mon_pkg::CTRL_OFF:     rd = {31'h0, run};
				ind_mon_pkg::IRQ_STAT_OFF: rd = {30'h0, irq_stat};
				ind_mon_pkg::IRQ_MASK_OFF: rd = {30'h0, irq_mask};
				ind_mon_pkg::EVT_STAT_OFF: rd = {31'h0, evt_full};
				ind_mon_pkg::EVT_DATA_OFF:
					rd = {24'h0, evt.inst, evt.on, 1'b0, evt.sig};
				ind_mon_pkg::EVT_TIME_OFF: rd = evt.stamp;
				ind_mon_pkg::TIME_OFF:     rd = ms_time;
				default:                   bad_addr = 1'b1;
			endcase
	end

	// one wait state: setup, access, ready on second access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc && !pready;
			prdata  <= (acc && !pready && !pwrite) ? rd : 32'h0;
			pslverr <= acc && !pready && bad_addr;
		end
	end

	// status only: no control outputs toward the switching object

	stamp_cur_a: assert property ( // RULE7
		@(posedge pclk) disable iff (!presetn)
		take |=> evt.stamp == $past(ms_time))
		else $error("event stamp not current ms");

	filter_on_a: assert property ( // RULE8
		@(posedge pclk) disable iff (!presetn)
		(!sel[0][0] && !pend[1]) |=> !pend[1])
		else $error("filtered ON event was queued");

	edge_pend_a: assert property ( // RULE6
		@(posedge pclk) disable iff (!presetn)
		(rise[0][1] && sel[0][0]) |=> pend[1] || evt_full)
		else $error("open rise not queued");

	cfg_frozen_a: assert property ( // RULE11
		@(posedge pclk) disable iff (!presetn)
		run && $past(run) |-> $stable(sel[0]))
		else $error("setting changed while running");

	open_dec_a: assert property ( // RULE3
		@(posedge pclk) disable iff (!presetn)
		(sync2[0].open_in && !sync2[0].close_in)
		|=> st[0] == ind_mon_pkg::ST_OPEN)
		else $error("open decode wrong");

	close_dec_a: assert property ( // RULE4
		@(posedge pclk) disable iff (!presetn)
		(!sync2[0].open_in && sync2[0].close_in)
		|=> st[0] == ind_mon_pkg::ST_CLOSED)
		else $error("close decode wrong");

endmodule // ind_status_monitor

// ===== pkg/ind_mon_pkg.sv
// package for the indicator status monitor: register map, field layout,
// reset values and event record format.
// assumes an apb master with 32-bit data and a 100 MHz pclk.
package ind_mon_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int N_INST      = 10;
	localparam int LABEL_CHARS = 32;
	localparam int LABEL_WORDS = LABEL_CHARS / 4;
	localparam int TS_W        = 32;
	localparam int CLK_MHZ     = 100;
	localparam int MS_NS       = 1000000;
	localparam int CLK_NS      = 1000 / CLK_MHZ;
	localparam int MS_CYCLES   = MS_NS / CLK_NS;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] CTRL_OFF      = 12'h000;
	localparam logic [11:0] IRQ_STAT_OFF  = 12'h004;
	localparam logic [11:0] IRQ_MASK_OFF  = 12'h008;
	localparam logic [11:0] EVT_STAT_OFF  = 12'h00C;
	localparam logic [11:0] EVT_DATA_OFF  = 12'h010;
	localparam logic [11:0] EVT_TIME_OFF  = 12'h014;
	localparam logic [11:0] TIME_OFF      = 12'h018;
	localparam logic [11:0] INST_BASE_OFF = 12'h100;
	localparam logic [11:0] LABEL_BASE_OFF = 12'h200;
	localparam logic [11:0] INST_STRIDE   = 12'h004;

	// ctrl fields
	localparam int CTRL_RUN_BIT = 0;
	// per-instance cfg fields
	localparam int CFG_ON_BIT   = 0;
	localparam int CFG_OFF_BIT  = 1;
	localparam int CFG_ST_LSB   = 8;
	// interrupt status bits
	localparam int IRQ_EVT_BIT  = 0;
	localparam int IRQ_OVF_BIT  = 1;

	localparam logic [1:0] CFG_SEL_RST = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		ST_INTER  = 4'h1,
		ST_OPEN   = 4'h2,
		ST_CLOSED = 4'h4,
		ST_BAD    = 4'h8
	} ind_state_t;

	// one event record as pushed into the event slot
	typedef struct packed {
		logic [3:0]      inst;
		logic [1:0]      sig;   // 0 inter, 1 open, 2 close, 3 bad
		logic            on;
		logic [TS_W-1:0] stamp;
	} event_rec_t;

	typedef struct packed {
		logic       open_in;
		logic       close_in;
	} status_in_t;

endpackage

// ===== rtl/ind_decode.sv
// one indicator instance: status decode and edge detection.
// assumes its inputs are already synchronised to pclk.
`timescale 1ns/10ps
module ind_decode (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// status inputs
	input  wire logic                     open_in,
	input  wire logic                     close_in,
	// decoded state and per-signal changes
	output ind_mon_pkg::ind_state_t       state,
	output logic [3:0]                    rise,
	output logic [3:0]                    fall
);

	ind_mon_pkg::ind_state_t next_state;
	logic [3:0]              prev;

	always_comb begin
		case ({open_in, close_in})
			2'h0:    next_state = ind_mon_pkg::ST_INTER;  // RULE1
			2'h2:    next_state = ind_mon_pkg::ST_OPEN;   // RULE3 RULE5
			2'h1:    next_state = ind_mon_pkg::ST_CLOSED; // RULE4 RULE5
			2'h3:    next_state = ind_mon_pkg::ST_BAD;    // RULE2
			default: next_state = ind_mon_pkg::ST_INTER;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ind_mon_pkg::ST_INTER;
			prev  <= 4'h1;
		end else begin
			state <= next_state;
			prev  <= state;
		end
	end

	// changes seen in the same cycle as the state register moves, for one cycle
	always_comb begin
		rise = state & ~prev;
		fall = prev & ~state;
	end

	state_onehot_a: assert property ( // RULE2
		@(posedge pclk) disable iff (!presetn)
		$onehot(state)) else $error("state not one-hot");

	decode_map_a: assert property ( // RULE2
		@(posedge pclk) disable iff (!presetn)
		(open_in && close_in) |=> state == ind_mon_pkg::ST_BAD)
		else $error("both active must decode bad");

	inter_map_a: assert property ( // RULE1
		@(posedge pclk) disable iff (!presetn)
		(!open_in && !close_in) |=> state == ind_mon_pkg::ST_INTER)
		else $error("none active must decode intermediate");

endmodule // ind_decode

// ===== bench/contact_model.sv
// model of the auxiliary contacts that feed the monitor's status pins.
// assumes the bench calls its tasks from one process running on pclk.
`timescale 1ns/10ps
module contact_model (
	// clock
	input  wire logic               pclk,
	// status pins toward the monitor
	output ind_mon_pkg::status_in_t pins [ind_mon_pkg::N_INST]
);
	initial begin
		for (int i = 0; i < ind_mon_pkg::N_INST; i++) begin
			pins[i] = '0;
		end
	end

	// two contacts, each driven on its own
	task automatic set_pair(input int i, input logic o, input logic c);
		@(posedge pclk);
		pins[i] <= '{open_in: o, close_in: c};
	endtask

	// one contact only: the second pin gets its inverse
	task automatic set_single(input int i, input logic o);
		@(posedge pclk);
		pins[i] <= '{open_in: o, close_in: ~o};
	endtask
endmodule // contact_model

// ===== bench/tb_top.sv
// self-checking bench for the indicator status monitor.
// assumes the contact model on the status pins and apb on pclk.
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic        err;
		logic [31:0] exp;
		logic [31:0] msk;
	} note_t;

	logic                    pclk, presetn, psel, penable, pwrite;
	logic                    pready, pslverr, irq;
	logic [11:0]             paddr;
	logic [31:0]             pwdata, prdata, rdata;
	logic [3:0]              pstrb;
	ind_mon_pkg::status_in_t pins [ind_mon_pkg::N_INST];
	int                      n_errors, total_checks, seed, inst;
	note_t                   notes [$];
	note_t                   cur;
	logic [3:0]              st_tab [4];
	logic [1:0]              sg_tab [4];

	always #5 pclk = ~pclk;

	ind_status_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.status_pins(pins), .irq(irq));
	contact_model i_part (.pclk(pclk), .pins(pins));

	// ****************************************
	// checking
	// ****************************************
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// results are compared here, apart from the driver
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			chk({pslverr, prdata & cur.msk}, {cur.err, cur.exp & cur.msk});
		end
	end

	// ****************************************
	// apb master
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
		input logic err);
		int k;
		notes.push_back('{err, e, m});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_errors++;
			final_report();
		end else begin
			rdata = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask

	function automatic logic [11:0] cfg_a(input int i);
		return ind_mon_pkg::INST_BASE_OFF + 12'(4 * i);
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		seed = 59359;
		st_tab = '{ind_mon_pkg::ST_OPEN, ind_mon_pkg::ST_BAD,
			ind_mon_pkg::ST_CLOSED, ind_mon_pkg::ST_INTER};
		sg_tab = '{2'h1, 2'h3, 2'h2, 2'h0};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(cfg_a(0), 32'h0000_0103, 32'h0000_0F03);
		rd(ind_mon_pkg::LABEL_BASE_OFF + 12'h020, 32'h3144_4E49,
			32'hFFFF_FFFF);
		wr(ind_mon_pkg::LABEL_BASE_OFF + 12'h044, 32'h5A59_5857);
		rd(ind_mon_pkg::LABEL_BASE_OFF + 12'h044, 32'h5A59_5857,
			32'hFFFF_FFFF);
		apb(1'b1, 12'h0FC, $random(seed), 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'h0FC, 32'h0, 32'h0, 32'h0, 1'b1);
		wr(ind_mon_pkg::IRQ_MASK_OFF, 32'h1);
		for (int j = 0; j < 2; j++) begin
			inst = j * 9;
			// keep ON only, so each change leaves exactly one record
			wr(cfg_a(inst), 32'h1);
			for (int t = 0; t < 4; t++) begin
				i_part.set_pair(inst, t < 2, t == 1 || t == 2);
				repeat (10) @(posedge pclk);
				rd(cfg_a(inst), {20'h0, st_tab[t], 8'h01}, 32'hF03);
				rd(ind_mon_pkg::EVT_STAT_OFF, 32'h1, 32'h1);
				rd(ind_mon_pkg::EVT_DATA_OFF,
					{24'h0, 4'(inst), 2'b10, sg_tab[t]}, 32'hFF);
				rd(ind_mon_pkg::EVT_TIME_OFF, 32'h0, 32'h0);
				rd(ind_mon_pkg::EVT_STAT_OFF, 32'h0, 32'h1);
			end
		end
		chk({32'h0, irq}, 33'h1);
		wr(ind_mon_pkg::IRQ_STAT_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk({32'h0, irq}, 33'h0);
		wr(ind_mon_pkg::IRQ_MASK_OFF, 32'h0);
		wr(cfg_a(0), 32'h2);
		wr(ind_mon_pkg::CTRL_OFF, 32'h1);
		wr(cfg_a(0), 32'h3);
		rd(cfg_a(0), 32'h0000_0102, 32'h0000_0F03);
		wr(ind_mon_pkg::LABEL_BASE_OFF + 12'h044, 32'h0);
		rd(ind_mon_pkg::LABEL_BASE_OFF + 12'h044, 32'h5A59_5857,
			32'hFFFF_FFFF);
		i_part.set_single(0, 1'b1);
		repeat (10) @(posedge pclk);
		rd(ind_mon_pkg::EVT_DATA_OFF, 32'h0, 32'hFF);
		// slot stays full, so the second open fall is merged
		for (int t = 0; t < 3; t++) begin
			i_part.set_single(0, t[0]);
			repeat (10) @(posedge pclk);
		end
		rd(ind_mon_pkg::IRQ_STAT_OFF, 32'h3, 32'h3);
		// whole run stays inside the first millisecond
		rd(ind_mon_pkg::EVT_TIME_OFF, 32'h0, 32'hFFFF_FFFF);
		rd(ind_mon_pkg::EVT_DATA_OFF, 32'h1, 32'hFF);
		chk({32'h0, irq}, 33'h0);
		final_report();
	end
endmodule // tb_top
